// ### dv/srcs_asserts.sv
`timescale 1ns/10ps
module srcs_asserts (
    // bus side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic        pready,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    // pins and outputs
    input wire logic        reset_pin_n,
    input wire logic [1:0]  ratio_pin,
    input wire logic [1:0]  boot_pin,
    input wire logic        pll_clk_level,
    input wire logic        reset_out_pin,
    input wire logic        core_run,
    input wire logic [5:0]  core_ratio,
    input wire logic [1:0]  boot_mode,
    input wire logic        pll_update
);
    logic [12:0] hi_ff;
    logic        sel_ff;
    logic [3:0]  strap_ff;
    logic        wr_pmc;
    logic [5:0]  exp_ratio;
    assign exp_ratio = strap_ff[3:2] == 2'b00 ? 6'h06 :
                       strap_ff[3:2] == 2'b01 ? 6'h20 :
                       strap_ff[3:2] == 2'b10 ? 6'h10 : 6'h00;
    assign wr_pmc = psel && penable && pready && pwrite && paddr == 12'h000;
    // ============================
    // cycles since pin release; straps seen under reset; output select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_ff    <= 13'h0000;
            sel_ff   <= 1'b0;
            strap_ff <= 4'h0;
        end else begin
            hi_ff <= !reset_pin_n ? 13'h0000 : hi_ff + {12'h000, ~&hi_ff};
            if (wr_pmc) sel_ff <= pwdata[12];
            if (!reset_pin_n) strap_ff <= {ratio_pin, boot_pin};
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_LOCK_MIN: assert property (
        $rose(core_run) |-> hi_ff >= 13'h1000 && hi_ff <= 13'h1008)
        else $error("core released outside lock window");
    AST_LOCK_MAX: assert property (
        hi_ff == 13'h100C |-> core_run)
        else $error("core not released after lock");
    AST_ROUT_HOLD: assert property (
        !sel_ff && !core_run |-> !reset_out_pin)
        else $error("reset out released early");
    AST_ROUT_RUN: assert property (
        core_run && !sel_ff && !$past(sel_ff, 3) |-> reset_out_pin)
        else $error("reset out low while running");
    AST_CLK_HI: assert property (
        (core_run && sel_ff && pll_clk_level) [*4] |-> reset_out_pin)
        else $error("clock out not following high");
    AST_CLK_LO: assert property (
        (core_run && sel_ff && !pll_clk_level) [*4] |-> !reset_out_pin)
        else $error("clock out not following low");
    AST_RATIO: assert property (
        core_run && reset_pin_n |-> core_ratio == exp_ratio)
        else $error("core ratio wrong");
    AST_BOOT: assert property (
        core_run && reset_pin_n |-> boot_mode == strap_ff[1:0])
        else $error("boot mode wrong");
    AST_RESTART: assert property (
        !reset_pin_n [*5] |-> !core_run)
        else $error("core runs under pin reset");
    AST_UPDATE: assert property (
        wr_pmc && core_run |-> ##[0:1] pll_update)
        else $error("no pll update on write");
endmodule
bind srcs_sequencer srcs_asserts srcs_asserts_i (.*);

// ### dv/srcs_board_model.sv
`timescale 1ns/10ps
module srcs_board_model (
    // clock and bench requests
    input  wire logic       pclk,
    input  wire logic       hold_rst,
    input  wire logic [1:0] ratio_sel,
    input  wire logic [1:0] boot_sel,
    // board pins
    output logic            reset_pin_n,
    output logic [1:0]      ratio_pin,
    output logic [1:0]      boot_pin,
    output logic            test_rst_pin_n,
    output logic            pll_clk_level
);
    logic [5:0] age;
    logic [2:0] ph;
    // ============================
    // power-up: reset and test reset low, pll clock level starts low at the board
    initial begin
        reset_pin_n = 1'b0;
        test_rst_pin_n = 1'b0;
        {ratio_pin, boot_pin, pll_clk_level, age, ph} = 0;
    end
    // straps only move while the pin reset is held, so they are valid early
    always @(posedge pclk) begin
        reset_pin_n <= !hold_rst;
        if (hold_rst && !reset_pin_n)
            {ratio_pin, boot_pin} <= {ratio_sel, boot_sel};
    end
    // end of test reset pulse; free-running pll level, 12-cycle period
    always @(posedge pclk) begin
        age <= age + 6'h01;
        if (age == 6'h28) test_rst_pin_n <= 1'b1;
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        if (ph == 3'h5) pll_clk_level <= ~pll_clk_level;
    end
endmodule

// ### dv/test_srcs_sequencer.sv
`timescale 1ns/10ps
module test_srcs_sequencer;
    logic        pclk = 1'b0, presetn = 1'b0, hold_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, d, r;
    logic        pready, pslverr, reset_pin_n, test_rst_pin_n, e;
    logic        pll_clk_level, reset_out_pin, core_run, test_reset_n;
    logic        pll_update;
    logic [1:0]  ratio_pin, boot_pin, boot_mode;
    logic [1:0]  ratio_sel = 2'b00, boot_sel = 2'b00;
    logic [5:0]  core_ratio;
    int          n_fail = 0, tests_run = 0, cyc = 0, i, n;
    srcs_sequencer   srcs_sequencer_i (.*);
    srcs_board_model srcs_board_model_i (.*);
    // ============================
    // clock never halted or slowed; hang guard
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end
    function automatic logic [5:0] ratio_of(input logic [1:0] c);
        return c == 2'b00 ? 6'h06 : c == 2'b01 ? 6'h20 :
               c == 2'b10 ? 6'h10 : 6'h00;
    endfunction
    task automatic chk(input string nm, input logic [31:0] s, x);
        tests_run++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
        end
    endtask
    // one apb transfer; waits on pready, not on a fixed count
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_fail++; // a missing answer counts as a mismatch
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // pin reset with given straps, then time the release
    task automatic boot(input logic [1:0] rc, bc);
        {hold_rst, ratio_sel, boot_sel} <= {1'b1, rc, bc};
        repeat (8) @(posedge pclk);
        chk("run_in_reset", core_run, 0);
        hold_rst <= 1'b0;
        n = 0;
        while (core_run !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        chk("lock_wait", n >= 4096 && n <= 4106, 1);
        chk("ratio", core_ratio, ratio_of(rc));
        chk("boot", boot_mode, bc);
        chk("rst_out", reset_out_pin, 1);
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ============================
    // main sequence
    initial begin
        n = $urandom(68);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("test_rst_lo", test_reset_n, 0);
        hold_rst <= 1'b0;
        repeat (200 + $urandom % 2800) @(posedge pclk);
        chk("aborted_lock", core_run, 0);
        for (i = 0; i < 4; i++) boot(2'(i), 2'(3 - i));
        boot(2'($urandom), 2'($urandom));
        chk("test_rst_hi", test_reset_n, 1);
        d = ($urandom & 32'h0000_0FFF) | 32'h0000_1000;
        apb(1'b1, 12'h000, d);
        chk("pmc_err", e, 0);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("pmc", r, d);
        repeat (30) @(posedge pclk);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk("bad_err", e, 1);
        chk("bad_data", r, 0);
        apb(1'b1, 12'h000, d & 32'hFFFF_EFFF);
        repeat (4) @(posedge pclk);
        chk("rst_out_back", reset_out_pin, 1);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("stat_state", r[1:0], srcs_pkg::ST_RUN);
        chk("stat_top", r[31:19], 0);
        hold_rst <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("rerun_stop", core_run, 0);
        chk("rerun_rst_out", reset_out_pin, 0);
        finish_test();
    end
endmodule

// ### verilog/srcs_pin_sync.sv
`timescale 1ns/10ps
module srcs_pin_sync (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // raw pins
    input  wire logic  reset_pin_n,
    input  wire logic [1:0] ratio_pin,
    input  wire logic [1:0] boot_pin,
    input  wire logic  test_rst_pin_n,
    // synchronised levels
    srcs_sync_if.src   sync
);
    logic [5:0] meta_ff;
    logic [5:0] sync_ff;

    // ========================================================
    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 6'h00;
            sync_ff <= 6'h00;
        end else begin
            meta_ff <= {test_rst_pin_n, boot_pin, ratio_pin, reset_pin_n};
            sync_ff <= meta_ff;
        end
    end

    assign sync.reset_n    = sync_ff[0];
    assign sync.ratio      = sync_ff[2:1];
    assign sync.boot       = sync_ff[4:3];
    assign sync.test_rst_n = sync_ff[5];
endmodule

// ### verilog/srcs_pkg.sv
// Function
// - after reset release wait 4096 input clocks, then start core at reset vector
// - reset-out indication stays active for the 4096-cycle lock delay
// - control bit 12 selects reset-out or pll clock out; reset-out default
// - start-up clock ratio comes from two ratio straps sampled during reset
// - software may change pll multiplier/divider any time after core leaves reset
// - ratio straps: 00=6:1, 01=32:1, 10=16:1, 11 reserved
// - boot straps: 00 spi slave, 01 spi master, 10 parallel flash, 11 reserved
package srcs_pkg;
    // ========================================================
    // register map
    localparam logic [11:0] PMC_ADDR       = 12'h000;
    localparam logic [11:0] STAT_ADDR      = 12'h004;
    localparam int          PMC_LOCAL_CLOCK_OUT_BIT = 12;
    localparam int          PMC_MUL_LSB    = 0;
    localparam int          PMC_DIV_LSB    = 6;
    localparam int          PMC_UPD_BIT    = 15;
    localparam logic [31:0] PMC_RESET      = 32'h0000_0000;
    // ========================================================
    // timing
    localparam int          LOCK_CYCLES    = 4096;
    localparam logic [12:0] LOCK_LAST      = 13'h0FFF;
    // ========================================================
    // ratio and boot decodes
    localparam logic [5:0]  RATIO_6        = 6'h06;
    localparam logic [5:0]  RATIO_32       = 6'h20;
    localparam logic [5:0]  RATIO_16       = 6'h10;
    localparam logic [5:0]  RATIO_NONE     = 6'h00;

    typedef enum logic [1:0] {
        BOOT_SPI_SLAVE  = 2'b00,
        BOOT_SPI_MASTER = 2'b01,
        BOOT_PAR_FLASH  = 2'b10,
        BOOT_RESERVED   = 2'b11
    } srcs_boot_type;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_LOCK  = 2'b01,
        ST_RUN   = 2'b10
    } srcs_state_type;
endpackage

// ### verilog/srcs_sequencer.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module srcs_sequencer (
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        reset_pin_n,
    input  wire logic [1:0]  ratio_pin,
    input  wire logic [1:0]  boot_pin,
    input  wire logic        test_rst_pin_n,
    input  wire logic        pll_clk_level,
    // outputs
    output logic             reset_out_pin,
    output logic             core_run,
    output logic [5:0]       core_ratio,
    output logic [1:0]       boot_mode,
    output logic             test_reset_n,
    output logic             pll_update
);
    // ========================================================
    // overview of the start-up flow
    //
    // everything here runs on pclk, which stands for the input clock of
    // the processor; there is no second clock, so the only crossings are
    // the board pins and the level of the pll clock, both of which pass
    // two flip-flops before any decision is made on them.
    //
    // the flow has three states:
    //   reset - the processor reset pin is low (after synchronising).
    //           straps are caught every cycle, so the last value seen
    //           before release is the one that counts.  the core is held
    //           and, with the clock-out bit clear, the shared pin shows reset-out low.
    //   lock  - the pin has been released.  a 13-bit counter walks from
    //           zero to its last value, one step per input clock, which
    //           is the time the pll is given to settle.  a low pin here
    //           drops straight back to reset and the count is lost.
    //   run   - the count has completed.  core_run rises and the core
    //           may fetch from its reset vector.  a low pin drops back
    //           to reset again.
    //
    // latency from the pin rising to core_run rising is two cycles of
    // synchroniser, one cycle for the state register to leave reset,
    // then the full lock count.  callers should not rely on the exact
    // handful of extra cycles; they come from the synchroniser and may
    // shift by one against the pin's own timing.
    //
    // the shared output pin has two jobs, picked by the clock-out bit
    // of the power management control word:
    //   bit clear - reset-out: low in reset and lock, high in run.
    //               this is the value after a bus reset, so a board
    //               that never touches the register sees reset-out.
    //   bit set   - local clock out: the pin mirrors the synchronised
    //               pll clock level.  the mirror lags the real clock by
    //               three cycles and can only show clocks slower than
    //               half of pclk; faster clocks alias.  a real device
    //               would route the clock through a glitch-free mux
    //               instead, which is outside this block.
    //
    // the power management control word is a plain 32-bit store.
    // writes are taken in any state, but the pll update pulse only
    // fires while the core runs, because before that the straps own
    // the clock ratio and a write must not disturb the lock count.
    //
    // the status word is read only and shows the state, the top bits
    // of the ratio, the boot code and the live lock counter.  the
    // counter is shown as is, so software polling it during lock sees
    // it move; it reads zero outside lock, except 4096 in the first run cycle.
    //
    // the bus side answers with zero wait states: pready rises in the
    // access cycle of every transfer.  addresses other than the two
    // registers read zero and raise pslverr; writes to them are lost.
    //
    // the test reset output simply follows its synchronised pin.  the
    // board is expected to pulse or hold it low after power-up; this
    // block does not stretch or filter that pulse.
    //
    // limitations:
    //   - a pin glitch shorter than one pclk period may be missed or
    //     may be seen as a full reset; no filter is applied.
    //   - the reserved ratio code decodes to zero, which downstream
    //     logic must treat as "no valid ratio".
    //   - the boot code is passed on raw, reserved code included.
    // ========================================================
    srcs_sync_if sync ();

    srcs_pin_sync u_sync (
        .pclk           (pclk),
        .presetn        (presetn),
        .reset_pin_n    (reset_pin_n),
        .ratio_pin      (ratio_pin),
        .boot_pin       (boot_pin),
        .test_rst_pin_n (test_rst_pin_n),
        .sync           (sync)
    );

    srcs_pkg::srcs_state_type state_ff;
    srcs_pkg::srcs_state_type nxt_state;
    logic [12:0]              cnt_ff;
    logic [31:0]              pmc_ff;
    logic                     pll_lvl_m_ff;
    logic                     pll_lvl_ff;
    logic                     wr_acc;
    logic                     rd_acc;
    logic [5:0]               nxt_ratio;
    logic [31:0]              stat_word;

    // ========================================================
    // start-up state machine
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            srcs_pkg::ST_RESET: begin
                // leave reset on the first synchronised high level
                if (sync.reset_n) begin
                    nxt_state = srcs_pkg::ST_LOCK;
                end
            end
            srcs_pkg::ST_LOCK: begin
                if (!sync.reset_n) begin
                    nxt_state = srcs_pkg::ST_RESET;
                end else if (cnt_ff == srcs_pkg::LOCK_LAST) begin
                    nxt_state = srcs_pkg::ST_RUN;
                end
            end
            srcs_pkg::ST_RUN: begin
                // a new pin reset always wins over a running core
                if (!sync.reset_n) begin
                    nxt_state = srcs_pkg::ST_RESET;
                end
            end
            default: begin
                // the unused code falls back to reset, never to run
                nxt_state = srcs_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= srcs_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // lock counter restarts from zero while reset is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 13'h0000;
        end else if (state_ff != srcs_pkg::ST_LOCK || !sync.reset_n) begin
            cnt_ff <= 13'h0000;
        end else begin
            cnt_ff <= cnt_ff + 13'h0001;
        end
    end

    // ========================================================
    // straps are caught while reset is held, so they are stable after
    always_comb begin
        unique case (sync.ratio)
            2'b00: begin
                nxt_ratio = srcs_pkg::RATIO_6;
            end
            2'b01: begin
                nxt_ratio = srcs_pkg::RATIO_32;
            end
            2'b10: begin
                nxt_ratio = srcs_pkg::RATIO_16;
            end
            2'b11: begin
                nxt_ratio = srcs_pkg::RATIO_NONE; // reserved
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ratio <= srcs_pkg::RATIO_NONE;
            boot_mode  <= srcs_pkg::BOOT_SPI_SLAVE;
        end else if (state_ff == srcs_pkg::ST_RESET) begin
            core_ratio <= nxt_ratio;
            boot_mode  <= sync.boot;
        end
    end

    // ========================================================
    // test reset follows the synchronised pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_reset_n <= 1'b0;
        end else begin
            test_reset_n <= sync.test_rst_n;
        end
    end

    // ========================================================
    // apb slave: zero wait states, unmapped reads zero with error
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;

    // status fields packed to exactly one word; upper bits read zero
    assign stat_word = {13'h0000, cnt_ff, boot_mode, core_ratio[5:4],
                        state_ff};

    // multiplier/divider writes only act once the core is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmc_ff     <= srcs_pkg::PMC_RESET;
            pll_update <= 1'b0;
        end else begin
            pll_update <= 1'b0;
            if (wr_acc && paddr == srcs_pkg::PMC_ADDR) begin
                pmc_ff     <= pwdata;
                pll_update <= (state_ff == srcs_pkg::ST_RUN);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != srcs_pkg::PMC_ADDR
                       && paddr != srcs_pkg::STAT_ADDR;
            if (rd_acc && paddr == srcs_pkg::PMC_ADDR) begin
                prdata <= pmc_ff;
            end else if (rd_acc && paddr == srcs_pkg::STAT_ADDR) begin
                prdata <= stat_word;
            end else if (rd_acc) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ========================================================
    // pll clock level comes from another domain: synchronise it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_lvl_m_ff <= 1'b0;
            pll_lvl_ff   <= 1'b0;
        end else begin
            pll_lvl_m_ff <= pll_clk_level;
            pll_lvl_ff   <= pll_lvl_m_ff;
        end
    end

    // shared pin: reset-out is low until lock completes, or clock out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_out_pin <= 1'b0;
            core_run      <= 1'b0;
        end else begin
            core_run <= (nxt_state == srcs_pkg::ST_RUN);
            if (pmc_ff[srcs_pkg::PMC_LOCAL_CLOCK_OUT_BIT]) begin
                reset_out_pin <= pll_lvl_ff;
            end else begin
                reset_out_pin <= (nxt_state == srcs_pkg::ST_RUN);
            end
        end
    end
endmodule

// ### verilog/srcs_sync_if.sv
`timescale 1ns/10ps
// synchronised pin levels handed to the sequencer
interface srcs_sync_if;
    logic       reset_n;
    logic [1:0] ratio;
    logic [1:0] boot;
    logic       test_rst_n;
    modport src (output reset_n, ratio, boot, test_rst_n);
    modport dst (input  reset_n, ratio, boot, test_rst_n);
endinterface
